/* File: bench/return_rotate_subtract_exec_bench.sv */
// self-checking bench for the executor, driving axi4-lite directly
`timescale 1ns/1ns
`default_nettype none
module return_rotate_subtract_exec_bench
   import rrs_pkg::*;
;
   // ==================================================
   // signals
   logic            clock, resetn;
   logic [7:0]      awAddr, arAddr;
   logic [31:0]     wData, rData, v;
   logic [3:0]      wStrb;
   logic [1:0]      bResp, rResp, r;
   logic            awValid, awReady, wValid, wReady, bValid, bReady;
   logic            arValid, arReady, rValid, rReady, intEn;
   logic [PC_W-1:0] pcOut;
   int              err_count, n_compared;

   rrs_exec u_dut (.clock(clock), .resetn(resetn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .pcOut(pcOut),
      .globalInterruptEnable(intEn));

   // ==================================================
   // common tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready judged at the falling edge, so the handshake edge sees settled values
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic aw, w;
      @(posedge clock);
      awAddr  <= a;
      wData   <= d;
      wStrb   <= 4'hF;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      do
      begin
         @(negedge clock);
         aw = awValid && awReady;
         w  = wValid && wReady;
         @(posedge clock);
         if (aw)
            awValid <= 1'b0;
         if (w)
            wValid <= 1'b0;
      end while ((awValid && !aw) || (wValid && !w));
      // bready raised late on purpose, so the response has to stand
      do @(negedge clock); while (bValid !== 1'b1);
      @(posedge clock);
      bReady <= 1'b1;
      @(negedge clock);
      rs = bResp;
      @(posedge clock);
      bReady <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      @(posedge clock);
      arAddr  <= a;
      arValid <= 1'b1;
      do @(negedge clock); while (arReady !== 1'b1);
      @(posedge clock);
      arValid <= 1'b0;
      do @(negedge clock); while (rValid !== 1'b1);
      @(posedge clock);
      rReady <= 1'b1;
      @(negedge clock);
      d  = rData;
      rs = rResp;
      @(posedge clock);
      rReady <= 1'b0;
   endtask

   function automatic logic [31:0] ins(input logic [3:0] op, input logic d, input logic [6:0] ra,
                                       input logic [7:0] im);
      return {8'h00, im, 1'b0, ra, 3'b000, d, op};
   endfunction

   // issue one instruction, then poll until busy clears
   task automatic ex(input logic [31:0] word);
      logic [31:0] s;
      wr(OFF_INSTR, word, r);
      do rd(OFF_STATUS, s, r); while (s[STS_BUSY] !== 1'b0);
   endtask

   // operand register, accumulator and flags in one go
   task automatic setup(input logic [7:0] rv, input logic [7:0] av, input logic [3:0] fl);
      wr(OFF_RDATA, {24'h0, rv}, r);
      wr(OFF_ACC, {24'h0, av}, r);
      wr(OFF_FLAGS, {28'h0, fl}, r);
   endtask

   // ==================================================
   // scenarios
   task automatic t_reset();
      rd(OFF_STATUS, v, r);
      chk(v, 32'h0);
      rd(OFF_ACC, v, r);
      chk(v, 32'h0);
      rd(OFF_PC, v, r);
      chk(v, 32'h0);
      chk({31'h0, intEn}, 32'h0);
      // unmapped place: refused both ways
      wr(8'h20, 32'h5A5A5A5A, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h20, v, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
   endtask

   task automatic t_nop();
      setup(8'h11, 8'h3C, 4'h7);
      wr(OFF_PC, 32'h0A0, r);
      ex(ins(OP_NOP, 1'b1, 7'h7F, 8'hFF));
      chk({21'h0, pcOut}, 32'h0A1);
      rd(OFF_ACC, v, r);
      chk(v, 32'h3C);
      rd(OFF_FLAGS, v, r);
      chk(v, 32'h7);
   endtask

   // left into the register, right into the accumulator; zero and digit carry preset high
   task automatic t_rot();
      wr(OFF_RADDR, 32'h7F, r);
      for (int i = 0; i < 2; i++)
      begin
         setup(8'hA5, 8'h00, 4'h6);
         ex(ins(i ? OP_RRC : OP_RLC, !i[0], 7'h7F, 8'h00));
         rd(i ? OFF_ACC : OFF_RDATA, v, r);
         chk(v, i ? 32'h52 : 32'h4A);
         rd(i ? OFF_RDATA : OFF_ACC, v, r);
         chk(v, i ? 32'hA5 : 32'h00);
         rd(OFF_FLAGS, v, r);
         chk(v, 32'h7);
      end
   endtask

   task automatic t_sbc();
      logic [7:0] rv[4];
      logic [7:0] av[4];
      logic [7:0] res[4];
      logic [3:0] fl[4];
      rv  = '{8'h05, 8'h05, 8'h06, 8'h06};
      av  = '{8'h06, 8'h06, 8'h05, 8'h05};
      res = '{8'hFE, 8'hFF, 8'h00, 8'h01}; // -2, -1, -0, +1
      fl  = '{4'h0, 4'h0, 4'h7, 4'h3};     // {ien, z, dc, c}
      wr(OFF_RADDR, 32'h00, r);
      for (int i = 0; i < 4; i++)
      begin
         setup(rv[i], av[i], {3'b000, i[0]});
         ex(ins(OP_SBC, i[1], 7'h00, 8'h00));
         rd(i[1] ? OFF_RDATA : OFF_ACC, v, r);
         chk(v, {24'h0, res[i]});
         rd(OFF_FLAGS, v, r);
         chk(v, {28'h0, fl[i]});
      end
   endtask

   // three pushes, then one of each return; status shows sp and flags
   task automatic t_ret();
      wr(OFF_PUSH, 32'h123, r);
      wr(OFF_PUSH, 32'h045, r);
      wr(OFF_PUSH, 32'h7FF, r);
      setup(8'h00, 8'hAA, 4'h7);
      ex(ins(OP_RETSUB, 1'b0, 7'h00, 8'h00));
      chk({21'h0, pcOut}, 32'h7FF);
      rd(OFF_STATUS, v, r);
      chk(v, 32'h720);
      ex(ins(OP_RETIMM, 1'b0, 7'h00, 8'h55));
      chk({21'h0, pcOut}, 32'h045);
      rd(OFF_ACC, v, r);
      chk(v, 32'h55);
      ex(ins(OP_RETINT, 1'b0, 7'h00, 8'h00));
      chk({21'h0, pcOut}, 32'h123);
      chk({31'h0, intEn}, 32'h1);
      rd(OFF_STATUS, v, r);
      chk(v, 32'hF00);
   endtask

   // ==================================================
   // run control
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // free-running 100 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // main sequence
   initial
   begin
      {resetn, awValid, wValid, bReady, arValid, rReady} = 6'h00;
      {awAddr, arAddr, wData, wStrb} = 52'h0;
      err_count  = 0;
      n_compared = 0;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      t_reset();
      t_nop();
      t_rot();
      t_sbc();
      t_ret();
      stop_test();
   end

   // hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule

bind rrs_exec rrs_exec_assertions u_chk (.clock(clock), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .pcOut(pcOut), .globalInterruptEnable(globalInterruptEnable));
`default_nettype wire

/* File: bench/rrs_exec_assertions.sv */
// protocol and execution checker bound to the executor top ports
`timescale 1ns/1ns
`default_nettype none
module rrs_exec_assertions
   import rrs_pkg::*;
(
   input wire logic            clock,
   input wire logic            resetn,
   input wire logic [7:0]      s_axi_awaddr,
   input wire logic            s_axi_awvalid,
   input wire logic            s_axi_awready,
   input wire logic [31:0]     s_axi_wdata,
   input wire logic [3:0]      s_axi_wstrb,
   input wire logic            s_axi_wvalid,
   input wire logic            s_axi_wready,
   input wire logic [1:0]      s_axi_bresp,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic [7:0]      s_axi_araddr,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic [1:0]      s_axi_rresp,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   input wire logic [PC_W-1:0] pcOut,
   input wire logic            globalInterruptEnable
);
   // ==================================================
   // helpers
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   // address and data taken together, as the bench always offers them
   wire logic wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // full-word instruction write; a write while busy would be dropped
   wire logic insWr  = wrTake && s_axi_awaddr == OFF_INSTR && s_axi_wstrb == 4'hF;

   // ==================================================
   // bus handshakes
   wr_answer_a: assert property (wrTake |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not one cycle after commit");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response changed before taken");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels ready while response pending");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after address");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before taken");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address ready while data pending");
   unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");

   // ==================================================
   // execution timing seen at the pins
   pc_step_a: assert property (insWr && s_axi_wdata[3:0] inside {OP_NOP, OP_RLC, OP_RRC, OP_SBC}
      |-> ##3 pcOut == $past(pcOut, 3) + 11'h001)
      else $error("single cycle op did not advance pc by one");
   enable_set_a: assert property (insWr && s_axi_wdata[3:0] == OP_RETINT
      |-> ##[3:5] globalInterruptEnable)
      else $error("interrupt return left global enable low");

   // main scenarios reached
   cover property (insWr && s_axi_wdata[3:0] == OP_SBC);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property ($rose(globalInterruptEnable));
endmodule
`default_nettype wire

/* File: logic/rrs_alu.sv */
// combinational datapath for rotates and subtract with carry
`timescale 1ns/1ns
`default_nettype none
module rrs_alu
   import rrs_pkg::*;
(
   input  wire logic [3:0] op,     // opcode
   input  wire logic [7:0] opnd,   // data register value
   input  wire logic [7:0] acc,    // accumulator
   input  wire logic       cIn,    // old carry
   output logic      [7:0] res,    // result byte
   output logic            cOut,   // new carry
   output logic            dcOut,  // new digit carry
   output logic            zOut,   // new zero
   output logic            resWr,  // result is to be written
   output logic            zdcWr   // zero and digit carry change
);
   // ==================================================
   // operation select
   logic [8:0] sum;  // byte sum with carry out
   logic [4:0] nib;  // low nibble sum for digit carry

   always_comb
   begin
      // subtract by adding the inverse; carry set means no borrow
      sum   = {1'b0, opnd} + {1'b0, ~acc} + {8'h00, cIn};
      nib   = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cIn};
      res   = 8'h00;
      cOut  = cIn;
      dcOut = 1'b0;
      zOut  = 1'b0;
      resWr = 1'b0;
      zdcWr = 1'b0;
      unique case (op)
         OP_RLC:
         begin
            res   = {opnd[6:0], cIn};
            cOut  = opnd[7];
            resWr = 1'b1;             // only carry moves
         end
         OP_RRC:
         begin
            res   = {cIn, opnd[7:1]};
            cOut  = opnd[0];
            resWr = 1'b1;
         end
         OP_SBC:
         begin
            res   = sum[7:0];
            cOut  = sum[8];
            dcOut = nib[4];
            zOut  = (sum[7:0] == 8'h00);
            resWr = 1'b1;
            zdcWr = 1'b1;
         end
         default:
         begin
            // other opcodes leave the datapath idle
            resWr = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: logic/rrs_exec.sv */
// executor for return, rotate, subtract and no-op instructions behind axi4-lite
// What this block does
// - immediate-return loads accumulator, pops PC, two cycles
// - plain return pops PC, flags untouched, two cycles
// - interrupt return pops PC, sets global enable
// - each return pops one stack level; on an empty stack it pops none
// - rotate left: carry in bit0, bit7 out
// - rotate right: carry in bit7, bit0 out
// - rotates take one cycle, change carry only
// - destination 0 accumulator, 1 data register
// - register address seven bits, locations 0..127
// - register plus inverse accumulator plus carry
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module rrs_exec
   import rrs_pkg::*;
(
   input  wire logic        clock,         // 100 MHz
   input  wire logic        resetn,        // async, active low
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [PC_W-1:0]  pcOut,         // program counter
   output logic             globalInterruptEnable
);
   // ==================================================
   // state of the whole block
   typedef struct packed {
      rrs_state_t                        st;     // sequencer
      logic [3:0]                        op;     // latched opcode
      logic                              dest;   // latched destination
      logic [RADR_W-1:0]                 radr;   // latched register address
      logic [7:0]                        imm;    // latched immediate
      logic [PC_W-1:0]                   pc;
      logic [7:0]                        acc;
      logic                              c;
      logic                              dc;
      logic                              z;
      logic                              ien;    // global interrupt enable
      logic [SP_W-1:0]                   sp;     // entries on stack
      logic [STK_DEPTH-1:0][PC_W-1:0]    stack;  // return addresses
      logic [REG_COUNT-1:0][7:0]         regs;   // data registers
      logic [RADR_W-1:0]                 ptr;    // software pointer
      logic                              awHeld; // write address captured
      logic [7:0]                        awAddr;
      logic                              wHeld;  // write data captured
      logic [31:0]                       wData;
      logic [3:0]                        wStrb;
      logic                              bValid;
      logic [1:0]                        bResp;
      logic                              rValid;
      logic [31:0]                       rData;
      logic [1:0]                        rResp;
   } rrs_core_t;

   rrs_core_t stFf;   // registered state
   rrs_core_t nxtSt;  // next state

   // ==================================================
   // datapath hookup
   // the operand comes from the latched address, so it
   // stays fixed for the whole execute cycle
   logic [7:0] opndVal; // register operand
   logic [7:0] aluRes;  // datapath result
   logic       aluC;
   logic       aluDc;
   logic       aluZ;
   logic       aluWr;
   logic       aluZdc;

   assign opndVal = stFf.regs[stFf.radr]; // full 0..127 space

   rrs_alu uAlu (
      .op    (stFf.op),
      .opnd  (opndVal),
      .acc   (stFf.acc),
      .cIn   (stFf.c),
      .res   (aluRes),
      .cOut  (aluC),
      .dcOut (aluDc),
      .zOut  (aluZ),
      .resWr (aluWr),
      .zdcWr (aluZdc)
   );

   // ==================================================
   // helper functions
   // is the byte address one of ours
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == OFF_INSTR) || (a == OFF_STATUS) || (a == OFF_ACC) ||
                 (a == OFF_PC) || (a == OFF_FLAGS) || (a == OFF_RADDR) ||
                 (a == OFF_RDATA) || (a == OFF_PUSH);
   endfunction

   // readback value; write-only words read zero
   function automatic logic [31:0] regRead(input rrs_core_t s, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         // the last issued instruction reads back as written
         OFF_INSTR:  v = {8'h00, s.imm, 1'b0, s.radr, 3'h0, s.dest, s.op};
         OFF_STATUS:
         begin
            v[STS_BUSY]                = (s.st != ST_IDLE);
            v[STS_SP_LSB +: SP_W]      = s.sp;
            v[STS_FLG_LSB + FLG_C]     = s.c;
            v[STS_FLG_LSB + FLG_DC]    = s.dc;
            v[STS_FLG_LSB + FLG_Z]     = s.z;
            v[STS_FLG_LSB + FLG_IEN]   = s.ien;
         end
         OFF_ACC:    v[7:0] = s.acc;
         OFF_PC:     v[PC_W-1:0] = s.pc;
         OFF_FLAGS:  v[3:0] = {s.ien, s.z, s.dc, s.c};
         OFF_RADDR:  v[RADR_W-1:0] = s.ptr;
         OFF_RDATA:  v[7:0] = s.regs[s.ptr];
         default:    v = 32'h0000_0000; // push and unmapped
      endcase
      regRead = v;
   endfunction

   // apply byte strobes over the current readback
   function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      strbMerge = (old & ~m) | (d & m);
   endfunction

   // ==================================================
   // bus handshakes are combinational off the state
   // no skid buffer: a captured half blocks its own channel
   assign s_axi_awready = !stFf.awHeld && !stFf.bValid;
   assign s_axi_wready  = !stFf.wHeld && !stFf.bValid;
   assign s_axi_arready = !stFf.rValid;
   assign s_axi_bvalid  = stFf.bValid;
   assign s_axi_bresp   = stFf.bResp;
   assign s_axi_rvalid  = stFf.rValid;
   assign s_axi_rdata   = stFf.rData;
   assign s_axi_rresp   = stFf.rResp;
   assign pcOut         = stFf.pc;
   assign globalInterruptEnable = stFf.ien;

   // ==================================================
   // next-state logic
   always_comb
   begin
      logic [31:0]       wv;   // merged write value
      logic [SP_W-1:0]   top;  // index of the top entry
      wv    = 32'h0000_0000;
      top   = stFf.sp - 4'h1;
      nxtSt = stFf;

      // address and data may arrive in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxtSt.awHeld = 1'b1;
         nxtSt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxtSt.wHeld = 1'b1;
         nxtSt.wData = s_axi_wdata;
         nxtSt.wStrb = s_axi_wstrb;
      end
      if (stFf.bValid && s_axi_bready)
      begin
         nxtSt.bValid = 1'b0;
      end

      // both halves held: commit once and answer
      if (stFf.awHeld && stFf.wHeld && !stFf.bValid)
      begin
         nxtSt.awHeld = 1'b0;
         nxtSt.wHeld  = 1'b0;
         nxtSt.bValid = 1'b1;
         nxtSt.bResp  = isMapped(stFf.awAddr) ? RESP_OKAY : RESP_SLVERR;
         wv = strbMerge(regRead(stFf, stFf.awAddr), stFf.wData, stFf.wStrb);
         // writes while busy are acknowledged but dropped, so software
         // never races the sequencer on the same state
         if (stFf.st == ST_IDLE)
         begin
            unique case (stFf.awAddr)
               OFF_INSTR:
               begin
                  nxtSt.op   = wv[INS_OP_LSB +: 4];
                  nxtSt.dest = wv[INS_DEST_BIT];
                  nxtSt.radr = wv[INS_RADR_LSB +: RADR_W];
                  nxtSt.imm  = wv[INS_IMM_LSB +: 8];
                  nxtSt.st   = ST_EXEC;
               end
               OFF_ACC:   nxtSt.acc = wv[7:0];
               OFF_PC:    nxtSt.pc  = wv[PC_W-1:0];
               OFF_FLAGS:
               begin
                  nxtSt.c   = wv[FLG_C];
                  nxtSt.dc  = wv[FLG_DC];
                  nxtSt.z   = wv[FLG_Z];
                  nxtSt.ien = wv[FLG_IEN];
               end
               OFF_RADDR: nxtSt.ptr = wv[RADR_W-1:0];
               OFF_RDATA: nxtSt.regs[stFf.ptr] = wv[7:0];
               OFF_PUSH:
               begin
                  // software fills the stack only through this word
                  // a full stack drops the push
                  if (stFf.sp != STK_DEPTH[SP_W-1:0])
                  begin
                     nxtSt.stack[stFf.sp[2:0]] = wv[PC_W-1:0];
                     nxtSt.sp = stFf.sp + 4'h1;
                  end
               end
               default:
               begin
                  // status and unmapped words are not writable; the
                  // answer picked above stands, so an unmapped
                  // place still reports an error
               end
            endcase
         end
      end

      // read side: one outstanding read
      // a read beside a commit still sees the old word
      if (stFf.rValid && s_axi_rready)
      begin
         nxtSt.rValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxtSt.rValid = 1'b1;
         nxtSt.rData  = regRead(stFf, s_axi_araddr);
         nxtSt.rResp  = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end

      // instruction sequencer
      // returns stay busy two cycles, all else one
      unique case (stFf.st)
         ST_IDLE:
         begin
            // launch handled by the instruction write above
            nxtSt.st = nxtSt.st;
         end
         ST_EXEC:
         begin
            nxtSt.st = ST_IDLE;
            if ((stFf.op == OP_RETSUB) || (stFf.op == OP_RETIMM) || (stFf.op == OP_RETINT))
            begin
               // pc from current top, then drop one level
               // an empty stack reads entry 0 and stays empty
               if (stFf.sp != RST_SP)
               begin
                  nxtSt.pc = stFf.stack[top[2:0]];
                  nxtSt.sp = top;
               end
               else
               begin
                  nxtSt.pc = stFf.stack[0];
               end
               if (stFf.op == OP_RETIMM)
               begin
                  nxtSt.acc = stFf.imm;
               end
               if (stFf.op == OP_RETINT)
               begin
                  nxtSt.ien = 1'b1;
               end
               nxtSt.st = ST_RET2;                  // second cycle
            end
            else
            begin
               // single-cycle group; unknown opcodes behave as no-op
               // the destination bit picks accumulator or register
               nxtSt.pc = stFf.pc + 11'h001;
               if (aluWr)
               begin
                  if (stFf.dest)
                  begin
                     nxtSt.regs[stFf.radr] = aluRes;
                  end
                  else
                  begin
                     nxtSt.acc = aluRes;
                  end
                  nxtSt.c = aluC;
               end
               if (aluZdc)
               begin
                  nxtSt.dc = aluDc;
                  nxtSt.z  = aluZ;
               end
            end
         end
         ST_RET2:
         begin
            // idle cycle closing a return; flags untouched
            nxtSt.st = ST_IDLE;
         end
         default:
         begin
            nxtSt.st = ST_IDLE;                      // illegal code recovers
         end
      endcase
   end

   // ==================================================
   // state register
   // the reset branch loads constants only: the struct is
   // cleared whole, then fields with named reset values
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         stFf        <= '0;
         stFf.st     <= ST_IDLE;
         stFf.pc     <= RST_PC;
         stFf.acc    <= RST_ACC;
         stFf.sp     <= RST_SP;
         stFf.bResp  <= RESP_OKAY;
         stFf.rResp  <= RESP_OKAY;
      end
      else
      begin
         stFf <= nxtSt;
      end
   end
endmodule
`default_nettype wire

/* File: logic/rrs_pkg.sv */
// shared constants and types for the return/rotate/subtract executor
`default_nettype none
package rrs_pkg;
   // ==================================================
   // sizes
   localparam int PC_W      = 11;  // program counter width
   localparam int STK_DEPTH = 8;   // hardware return stack levels
   localparam int SP_W      = 4;   // stack pointer, counts 0..8
   localparam int RADR_W    = 7;   // data register address, 0..127
   localparam int REG_COUNT = 128; // data register locations

   // ==================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_INSTR  = 8'h00; // issue an instruction
   localparam logic [7:0] OFF_STATUS = 8'h04; // busy, stack pointer, flags
   localparam logic [7:0] OFF_ACC    = 8'h08; // accumulator
   localparam logic [7:0] OFF_PC     = 8'h0C; // program counter
   localparam logic [7:0] OFF_FLAGS  = 8'h10; // carry, digit carry, zero, gie
   localparam logic [7:0] OFF_RADDR  = 8'h14; // data register pointer
   localparam logic [7:0] OFF_RDATA  = 8'h18; // data register at pointer
   localparam logic [7:0] OFF_PUSH   = 8'h1C; // push a return address

   // ==================================================
   // field positions
   localparam int INS_OP_LSB   = 0;  // opcode [3:0]
   localparam int INS_DEST_BIT = 4;  // destination select
   localparam int INS_RADR_LSB = 8;  // register address [14:8]
   localparam int INS_IMM_LSB  = 16; // immediate [23:16]
   localparam int FLG_C        = 0;
   localparam int FLG_DC       = 1;
   localparam int FLG_Z        = 2;
   localparam int FLG_IEN      = 3;
   localparam int STS_BUSY     = 0;
   localparam int STS_SP_LSB   = 4;  // stack pointer [7:4]
   localparam int STS_FLG_LSB  = 8;  // flag copy [11:8]

   // ==================================================
   // reset values and bus answers
   localparam logic [PC_W-1:0] RST_PC  = 11'h000;
   localparam logic [7:0]      RST_ACC = 8'h00;
   localparam logic [SP_W-1:0] RST_SP  = 4'h0;
   localparam logic [1:0]      RESP_OKAY   = 2'h0;
   localparam logic [1:0]      RESP_SLVERR = 2'h2;

   // ==================================================
   // types
   typedef enum logic [3:0] {
      OP_NOP    = 4'b0000, // no_operation
      OP_RETSUB = 4'b0001, // subroutine_return
      OP_RETIMM = 4'b0010, // return_with_immediate
      OP_RETINT = 4'b0011, // return_from_interrupt
      OP_RLC    = 4'b0100, // rotate_left_carry
      OP_RRC    = 4'b0101, // rotate_right_carry
      OP_SBC    = 4'b0110  // subtract_acc_carry_from_reg
   } rrs_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, // waiting for an instruction
      ST_EXEC = 2'b01, // first instruction cycle
      ST_RET2 = 2'b10  // second cycle of a return
   } rrs_state_t;
endpackage
`default_nettype wire
